// ---- tb/fdx_exec_properties.sv ----
// Purpose: timing and effect checks at the executor's ports
// Assumes: one clock domain, reset active high
// Notes: bound to every fdx_exec instance
`timescale 1ns/10ps
module fdx_exec_props #(
	parameter int ADDR_W = 16
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire fdx_pkg::fdx_op_t instr_op,
	input wire logic [15:0] instr_k,
	input wire logic [ADDR_W-1:0] dmem_addr,
	input wire logic dmem_re,
	input wire logic dmem_we,
	input wire logic pmem_re,
	input wire logic pmem_we,
	input wire logic sleep_req,
	input wire logic wdt_kick,
	input wire logic debug_en,
	input wire logic break_req,
	input wire logic [7:0] flag_register
);
	import fdx_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// accepted operation and its class
	wire acc = instr_valid && instr_ready;
	wire is_rd = instr_op inside {OP_FETCH_IND, OP_FETCH_DIR, OP_POP};
	wire is_wr = instr_op inside {OP_SAVE_IND, OP_SAVE_DIR, OP_PUSH};
	wire is_flag = instr_op inside {OP_FLAG_SET, OP_FLAG_CLR};
	wire [7:0] bit_sel = 8'h01 << instr_k[2:0];
	property p_flag_set;
		acc && instr_op == OP_FLAG_SET |=> flag_register == ($past(flag_register) | $past(bit_sel));
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag set wrong");
	property p_flag_clr;
		acc && instr_op == OP_FLAG_CLR |=> flag_register == ($past(flag_register) & ~$past(bit_sel));
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag clear wrong");
	property p_flags_kept;
		acc && !is_flag |=> $stable(flag_register) [*2];
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("flags moved");
	property p_two_cycle;
		acc && (is_rd || is_wr || instr_op == OP_CODE_WRITE) |=> !instr_ready ##1 instr_ready;
	endproperty
	a_two_cycle: assert property (p_two_cycle) else $error("not two cycles");
	property p_code_three;
		acc && instr_op == OP_CODE_FETCH |=> pmem_re && !instr_ready ##1 !instr_ready ##1 instr_ready;
	endproperty
	a_code_three: assert property (p_code_three) else $error("code fetch timing");
	property p_read_strobe;
		acc && is_rd |=> dmem_re && !dmem_we ##1 !dmem_re;
	endproperty
	a_read_strobe: assert property (p_read_strobe) else $error("read strobe wrong");
	property p_write_strobe;
		acc && is_wr |=> dmem_we && !dmem_re ##1 !dmem_we;
	endproperty
	a_write_strobe: assert property (p_write_strobe) else $error("write strobe wrong");
	property p_direct_addr;
		acc && instr_op inside {OP_FETCH_DIR, OP_SAVE_DIR} |=> dmem_addr == ADDR_W'($past(instr_k));
	endproperty
	a_direct_addr: assert property (p_direct_addr) else $error("direct address wrong");
	property p_ctrl_pulse;
		acc && instr_op inside {OP_SLEEP, OP_WDT_KICK} |=> (sleep_req == $past(instr_op == OP_SLEEP))
			&& (wdt_kick != sleep_req) ##1 !sleep_req && !wdt_kick;
	endproperty
	a_ctrl_pulse: assert property (p_ctrl_pulse) else $error("control pulse wrong");
	property p_break;
		acc && instr_op == OP_BREAK |=> break_req == $past(debug_en);
	endproperty
	a_break: assert property (p_break) else $error("break pulse wrong");
	property p_code_write;
		acc && instr_op == OP_CODE_WRITE |=> pmem_we && !dmem_we;
	endproperty
	a_code_write: assert property (p_code_write) else $error("code write strobe missing");
endmodule
bind fdx_exec fdx_exec_props #(.ADDR_W(ADDR_W)) u_props (.core_clk(core_clk), .reset(reset),
	.instr_valid(instr_valid), .instr_ready(instr_ready), .instr_op(instr_op), .instr_k(instr_k),
	.dmem_addr(dmem_addr), .dmem_re(dmem_re), .dmem_we(dmem_we), .pmem_re(pmem_re),
	.pmem_we(pmem_we), .sleep_req(sleep_req), .wdt_kick(wdt_kick), .debug_en(debug_en),
	.break_req(break_req), .flag_register(flag_register));

// ---- tb/fdx_exec_tb.sv ----
// Purpose: self-checking bench of the flag and data transfer executor
// Assumes: one AHB-Lite master, memory model on the far side
// Notes: registers are observed by storing them to a fixed data address
`timescale 1ns/10ps
module fdx_exec_tb;
	import fdx_pkg::*;
	logic core_clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, debug_en = 1'b0;
	fdx_op_t instr_op = OP_NOP;
	logic [4:0] instr_rd = 5'h00, instr_rr = 5'h00;
	logic [1:0] instr_ptr = 2'h0;
	fdx_amode_t instr_amode = AM_PLAIN;
	logic [15:0] instr_k = 16'h0000;
	logic hsel = 1'b0, hwrite = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	wire logic instr_ready, dmem_re, dmem_we, pmem_re, pmem_we, sleep_req, wdt_kick;
	wire logic break_req, hreadyout, hresp;
	wire logic [15:0] dmem_addr, pmem_wdata, pmem_rdata;
	wire logic [14:0] pmem_addr;
	wire logic [7:0] dmem_wdata, dmem_rdata, flag_register;
	wire logic [31:0] hrdata;
	logic [31:0] r;
	logic [7:0] v, e, wd;
	logic [15:0] pv, ea, np, z, w, ra, wa, pwd;
	logic [14:0] pa, pwa;
	logic [5:0] q;
	logic [4:0] rd, rr;
	logic [1:0] pp;
	fdx_amode_t am;
	logic [7:0] rv [0:31];
	logic [7:0] sh [logic [15:0]];
	int bad_count = 0, n_checks = 0, n_sl = 0, n_wd = 0, n_br = 0;
	fdx_exec dut (.core_clk, .reset, .instr_valid, .instr_ready, .instr_op, .instr_rd, .instr_rr,
		.instr_ptr, .instr_amode, .instr_k, .dmem_addr, .dmem_re, .dmem_we, .dmem_wdata,
		.dmem_rdata, .pmem_addr, .pmem_re, .pmem_we, .pmem_wdata, .pmem_rdata, .sleep_req,
		.wdt_kick, .debug_en, .break_req, .flag_register, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata);
	fdx_mem_model mem (.core_clk, .dmem_addr, .dmem_re, .dmem_we, .dmem_wdata, .dmem_rdata,
		.pmem_addr, .pmem_re, .pmem_we, .pmem_wdata, .pmem_rdata);
	initial forever #5 core_clk = ~core_clk;
	// strobe capture at the falling edge, where outputs have settled
	always @(negedge core_clk) begin
		if (dmem_re === 1'b1) ra = dmem_addr;
		if (dmem_we === 1'b1) {wa, wd} = {dmem_addr, dmem_wdata};
		if (pmem_re === 1'b1) pa = pmem_addr;
		if (pmem_we === 1'b1) {pwa, pwd} = {pmem_addr, pmem_wdata};
		n_sl += int'(sleep_req === 1'b1);
		n_wd += int'(wdt_kick === 1'b1);
		n_br += int'(break_req === 1'b1);
	end
	task chk(input logic [31:0] seen, input logic [31:0] ex);
		n_checks++;
		if (seen !== ex) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, ex);
		end
	endtask
	task print_verdict;
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// one bus transfer; hreadyout is the bus hready
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rdv);
		@(posedge core_clk);
		{hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, wr};
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		rdv = hrdata;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] ex);
		ahb(1'b0, a, 32'h0, r);
		chk(r, ex);
		chk(hresp, 1'b0);
	endtask
	// bounded wait; a ready that never comes shows up in later checks
	task wait_rdy;
		repeat (8) if (instr_ready !== 1'b1) @(negedge core_clk);
	endtask
	task issue(input fdx_op_t op, input logic [4:0] d, input logic [4:0] s, input logic [1:0] p,
		input fdx_amode_t m, input logic [15:0] k);
		@(posedge core_clk);
		instr_valid <= 1'b1;
		{instr_rd, instr_rr, instr_ptr, instr_k} <= {d, s, p, k};
		instr_op <= op;
		instr_amode <= m;
		@(negedge core_clk);
		wait_rdy;
		@(posedge core_clk);
		instr_valid <= 1'b0;
		@(negedge core_clk);
		wait_rdy;
		@(negedge core_clk);
	endtask
	task setr(input logic [4:0] d, input logic [7:0] x);
		issue(OP_LOAD_IMM, d, 5'h00, 2'h0, AM_PLAIN, {8'h00, x});
		rv[d] = x;
	endtask
	task setp(input logic [1:0] p, input logic [15:0] x);
		setr(PTR_FIRST_IDX + {2'b0, p, 1'b0}, x[7:0]);
		setr(PTR_FIRST_IDX + {2'b0, p, 1'b1}, x[15:8]);
	endtask
	task obs(input logic [4:0] s, input logic [7:0] ex);
		issue(OP_SAVE_DIR, 5'h00, s, 2'h0, AM_PLAIN, 16'h0300);
		chk(wa, 16'h0300);
		chk(wd, ex);
		sh[16'h0300] = ex;
	endtask
	function automatic logic [7:0] mexp(input logic [15:0] a);
		return sh.exists(a) ? sh[a] : a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction
	function automatic logic [15:0] eaddr(input logic [15:0] b, input logic [1:0] p,
		input fdx_amode_t m, input logic [5:0] d);
		if (m == AM_PRE_DEC) return b - 16'h0001;
		if (m == AM_DISP && p != PTR_X) return b + {10'h000, d};
		return b;
	endfunction
	function automatic logic [15:0] nptr(input logic [15:0] b, input fdx_amode_t m);
		return (m == AM_POST_INC) ? b + 16'h0001 : (m == AM_PRE_DEC) ? b - 16'h0001 : b;
	endfunction
	// watchdog far beyond the expected run of under a thousand cycles
	initial begin
		#200000;
		bad_count++;
		print_verdict;
	end
	initial begin
		void'($urandom(98));
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		rchk(OFS_CTRL, CTRL_RESET);
		rchk(OFS_FLAGS, {24'h0, FLAGS_RESET});
		rchk(OFS_STATUS, 32'h00000001);
		rchk(OFS_SP, {16'h0, SP_RESET});
		ahb(1'b1, 8'h20, 32'($urandom), r);
		rchk(8'h20, 32'h0);
		ahb(1'b1, OFS_CTRL, 32'h0, r);
		rchk(OFS_STATUS, 32'h00000011);
		ahb(1'b1, OFS_CTRL, 32'h1, r);
		for (int i = 0; i < 16; i++) begin
			v = 8'($urandom);
			ahb(1'b1, OFS_FLAGS, {24'h0, v}, r);
			issue(i[3] ? OP_FLAG_CLR : OP_FLAG_SET, 5'h00, 5'h00, 2'h0, AM_PLAIN, 16'(i % 8));
			e = i[3] ? v & ~(8'h01 << i[2:0]) : v | (8'h01 << i[2:0]);
			chk(flag_register, e);
		end
		for (int i = 0; i < 26; i++) setr(5'(i), 8'($urandom));
		// every pointer with the plain, post-increment, pre-decrement and offset modes, load then save
		for (int i = 0; i < 12; i++) begin
			{pp, pv, q} = {2'(i % 3), 16'($urandom), 6'($urandom)};
			am = fdx_amode_t'(i / 3);
			{rd, rr} = {5'(2 + $urandom % 20), 5'($urandom % 26)};
			setp(pp, pv);
			issue(OP_FETCH_IND, rd, 5'h00, pp, am, {10'h0, q});
			ea = eaddr(pv, pp, am, q);
			chk(ra, ea);
			obs(rd, mexp(ea));
			rv[rd] = mexp(ea);
			np = nptr(pv, am);
			issue(OP_SAVE_IND, 5'h00, rr, pp, am, {10'h0, q});
			ea = eaddr(np, pp, am, q);
			chk(wa, ea);
			chk(wd, rv[rr]);
			sh[ea] = rv[rr];
			issue(OP_FETCH_IND, rd, 5'h00, pp, AM_PLAIN, 16'h0000);
			chk(ra, nptr(np, am));
			rv[rd] = mexp(nptr(np, am));
		end
		for (int i = 0; i < 4; i++) begin
			{pv, rd} = {(i == 0) ? 16'hFFFF : 16'($urandom), 5'(2 + $urandom % 20)};
			issue(OP_FETCH_DIR, rd, 5'h00, 2'h0, AM_PLAIN, pv);
			chk(ra, pv);
			obs(rd, mexp(pv));
			rv[rd] = mexp(pv);
		end
		ahb(1'b1, OFS_SP, 32'h00000480, r);
		for (int i = 0; i < 2; i++) begin
			rr = 5'(i * 7 + 3);
			issue(OP_PUSH, 5'h00, rr, 2'h0, AM_PLAIN, 16'h0000);
			chk(wa, 16'h0480 - 16'(i));
			chk(wd, rv[rr]);
			sh[16'h0480 - 16'(i)] = rv[rr];
		end
		for (int i = 0; i < 2; i++) begin
			issue(OP_POP, 5'h16, 5'h00, 2'h0, AM_PLAIN, 16'h0000);
			chk(ra, 16'h047F + 16'(i));
			obs(5'h16, rv[5'(10 - i * 7)]);
		end
		rchk(OFS_SP, 32'h00000480);
		for (int i = 0; i < 4; i++) begin
			{z, rd} = {16'($urandom), (i == 0) ? 5'h00 : 5'(2 + $urandom % 20)};
			am = fdx_amode_t'(i % 2);
			setp(PTR_Z, z);
			issue(OP_CODE_FETCH, rd, 5'h00, PTR_Z, am, 16'h0000);
			chk(pa, z[15:1]);
			w = {1'b0, z[15:1]} ^ 16'hC3A5;
			obs(rd, z[0] ? w[15:8] : w[7:0]);
			rchk(OFS_PTRZ, {16'h0, nptr(z, am)});
		end
		setr(5'h00, 8'($urandom));
		setr(5'h01, 8'($urandom));
		setp(PTR_Z, 16'($urandom));
		issue(OP_CODE_WRITE, 5'h00, 5'h00, PTR_Z, AM_PLAIN, 16'h0000);
		chk(pwa, {rv[31], rv[30]} >> 1);
		chk(pwd, {rv[1], rv[0]});
		issue(OP_SLEEP, 5'h00, 5'h00, 2'h0, AM_PLAIN, 16'h0000);
		issue(OP_WDT_KICK, 5'h00, 5'h00, 2'h0, AM_PLAIN, 16'h0000);
		issue(OP_BREAK, 5'h00, 5'h00, 2'h0, AM_PLAIN, 16'h0000);
		@(posedge core_clk);
		debug_en <= 1'b1;
		issue(OP_BREAK, 5'h00, 5'h00, 2'h0, AM_PLAIN, 16'h0000);
		chk({n_sl[3:0], n_wd[3:0]}, 8'h11);
		chk(n_br, 1);
		print_verdict;
	end
endmodule

// ---- tb/fdx_mem_model.sv ----
// Purpose: data and code memory seen by the executor
// Assumes: reads answer in the strobe cycle, writes land at the closing edge
// Notes: idle read lines toggle so stale data cannot pass for a reply
`timescale 1ns/10ps
module fdx_mem_model (
	input wire logic core_clk,
	input wire logic [15:0] dmem_addr,
	input wire logic dmem_re,
	input wire logic dmem_we,
	input wire logic [7:0] dmem_wdata,
	output logic [7:0] dmem_rdata,
	input wire logic [14:0] pmem_addr,
	input wire logic pmem_re,
	input wire logic pmem_we,
	input wire logic [15:0] pmem_wdata,
	output logic [15:0] pmem_rdata
);
	logic [7:0] dm [0:65535];
	logic [15:0] pm [0:32767];
	logic tog = 1'b0;
	// known contents so the bench can predict every byte
	initial begin
		for (int i = 0; i < 65536; i++) dm[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3C;
		for (int i = 0; i < 32768; i++) pm[i] = 16'(i) ^ 16'hC3A5;
	end
	// writes and the idle toggle
	always @(posedge core_clk) begin
		tog <= ~tog;
		if (dmem_we) dm[dmem_addr] <= dmem_wdata;
		if (pmem_we) pm[pmem_addr] <= pmem_wdata;
	end
	assign dmem_rdata = dmem_re ? dm[dmem_addr] : {8{tog}};
	assign pmem_rdata = pmem_re ? pm[pmem_addr] : {16{~tog}};
endmodule

// ---- verilog/fdx_addr_gen.sv ----
// Purpose: effective address and pointer update for one pointer
// Assumes: displacement is unsigned, wrap-around at the pointer width
// Notes: used for the X/Y/Z pointers and for the stack pointer
`timescale 1ns/10ps
module fdx_addr_gen #(
	parameter int W = 16,
	parameter int DW = 6
) (
	input wire logic [W-1:0] base,
	input wire fdx_pkg::fdx_amode_t mode,
	input wire logic [DW-1:0] disp,
	output logic [W-1:0] eff_addr,
	output logic [W-1:0] next_base
);
	import fdx_pkg::*;

	wire [W-1:0] base_inc = base + W'(1);
	wire [W-1:0] base_dec = base - W'(1);
	wire [W-1:0] base_disp = base + W'(disp);

	// pre-modes address the moved pointer, post-modes the old one
	assign eff_addr = (mode == AM_PRE_DEC) ? base_dec :
		(mode == AM_PRE_INC) ? base_inc :
		(mode == AM_DISP) ? base_disp : base;

	// displacement leaves the pointer where it was
	assign next_base = (mode == AM_POST_INC || mode == AM_PRE_INC) ? base_inc :
		(mode == AM_PRE_DEC || mode == AM_POST_DEC) ? base_dec : base;
endmodule

// ---- verilog/fdx_exec.sv ----
// Purpose: executes flag, data transfer and control operations of the core
// Assumes: decoded operation fields arrive with instr_valid, memory reads return
//   data in the cycle of the read strobe, one AHB-Lite master
// Notes: pointer pairs live in flops beside the register array
// How it works
// - irq_on sets, irq_off clears I, one cycle
// - sign flag forced high or low, one cycle
// - overflow flag forced high or low, one cycle
// - bit copy flag set or cleared, one cycle
// - half carry set or cleared, one cycle
// - indirect load then pointer plus one, two cycles
// - pointer minus one then indirect load, two cycles
// - Y/Z plus offset load, pointer kept, two cycles
// - indirect save then pointer plus one, two cycles
// - pointer minus one then indirect save, two cycles
// - Y/Z plus offset save, pointer kept, two cycles
// - direct address load into register, two cycles
// - register saved at direct address, two cycles
// - code byte at Z to register, optional Z+1, three cycles
// - push register onto stack, two cycles
// - pop register from stack, two cycles
// - sleep and watchdog kick: one cycle, pulse out
// - break only acts when debug is present
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
module fdx_exec #(
	parameter int ADDR_W = 16,
	parameter int HADDR_W = 8
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire fdx_pkg::fdx_op_t instr_op,
	input wire logic [4:0] instr_rd,
	input wire logic [4:0] instr_rr,
	input wire logic [1:0] instr_ptr,
	input wire fdx_pkg::fdx_amode_t instr_amode,
	input wire logic [15:0] instr_k,
	output logic [ADDR_W-1:0] dmem_addr,
	output logic dmem_re,
	output logic dmem_we,
	output logic [7:0] dmem_wdata,
	input wire logic [7:0] dmem_rdata,
	output logic [ADDR_W-2:0] pmem_addr,
	output logic pmem_re,
	output logic pmem_we,
	output logic [15:0] pmem_wdata,
	input wire logic [15:0] pmem_rdata,
	output logic sleep_req,
	output logic wdt_kick,
	input wire logic debug_en,
	output logic break_req,
	output logic [7:0] flag_register,
	input wire logic hsel,
	input wire logic [HADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);
	import fdx_pkg::*;

	fdx_state_t state_r, state_nxt;
	logic [7:0] flags_r, flags_nxt;
	logic [15:0] sp_r, sp_nxt;
	logic [15:0] ptr_r [3];
	logic ctrl_en_r;
	logic [4:0] rd_r;
	logic src_hi_r;
	logic [7:0] src_byte_r;
	logic code_hi_r;
	logic [7:0] code_byte_r;
	logic [ADDR_W-1:0] dmem_addr_r;
	logic dmem_re_r, dmem_we_r;
	logic [ADDR_W-2:0] pmem_addr_r;
	logic pmem_re_r, pmem_we_r;
	logic sleep_r, wdt_r, break_r;
	logic ahb_wr_r;
	logic [HADDR_W-1:0] ahb_addr_r;
	logic [31:0] hrdata_r;
	logic [7:0] rf_a, rf_b;

	// decode of the offered operation
	wire accept = instr_valid & instr_ready;
	wire op_fetch_ind = instr_op == OP_FETCH_IND;
	wire op_save_ind = instr_op == OP_SAVE_IND;
	wire op_code_rd = instr_op == OP_CODE_FETCH;
	wire op_code_wr = instr_op == OP_CODE_WRITE;
	wire op_push = instr_op == OP_PUSH;
	wire op_pop = instr_op == OP_POP;
	wire op_dir = instr_op == OP_FETCH_DIR || instr_op == OP_SAVE_DIR;
	wire op_two = op_fetch_ind | op_save_ind | op_dir | op_push | op_pop | op_code_wr;
	wire op_load = op_fetch_ind | op_pop | instr_op == OP_FETCH_DIR;
	wire op_store = op_save_ind | op_push | instr_op == OP_SAVE_DIR;

	// code memory always goes through Z
	wire [1:0] psel = (op_code_rd | op_code_wr) ? PTR_Z :
		(instr_ptr == PTR_X || instr_ptr == PTR_Y) ? instr_ptr : PTR_Z;
	wire [15:0] psel_val = ptr_r[psel];

	// offset exists only for Y and Z; on X it degrades to a plain access
	wire disp_ok = psel != PTR_X;
	wire fdx_amode_t pmode = op_code_rd ? (instr_amode == AM_POST_INC ? AM_POST_INC : AM_PLAIN) :
		(instr_amode == AM_DISP && !disp_ok) ? AM_PLAIN : instr_amode;
	wire [15:0] p_eff, p_next, s_eff, s_next;

	// pointer arithmetic for X/Y/Z
	fdx_addr_gen #(.W(16), .DW(6)) u_ptr_gen (
		.base(psel_val),
		.mode(pmode),
		.disp(instr_k[5:0]),
		.eff_addr(p_eff),
		.next_base(p_next)
	);

	// stack grows downward: push posts a decrement, pop pre-increments
	fdx_addr_gen #(.W(16), .DW(6)) u_sp_gen (
		.base(sp_r),
		.mode(op_push ? AM_POST_DEC : AM_PRE_INC),
		.disp(6'h00),
		.eff_addr(s_eff),
		.next_base(s_next)
	);

	// data memory address of the accepted operation
	wire [15:0] mem_addr = (op_push | op_pop) ? s_eff : op_dir ? instr_k : p_eff;
	wire ptr_move = accept & (op_fetch_ind | op_save_ind | op_code_rd) &
		(pmode == AM_POST_INC || pmode == AM_PRE_DEC);

	// source operand; pointer bytes come from the pointer flops, not the array
	wire rr_hi = instr_rr >= PTR_FIRST_IDX;
	wire [1:0] rr_pair = 2'(instr_rr[2:1] - 2'h1);
	wire [15:0] rr_ptr = ptr_r[rr_pair];
	wire [7:0] rr_byte = instr_rr[0] ? rr_ptr[15:8] : rr_ptr[7:0];
	wire [7:0] src_data = src_hi_r ? src_byte_r : rf_a;

	// write back: immediate at accept, loads in the access cycle, code byte last
	wire wb_imm = accept & instr_op == OP_LOAD_IMM;
	wire wb_load = state_r == S_ACC && !dmem_we_r && dmem_re_r;
	wire wb_code = state_r == S_PWB;
	wire wb_en = wb_imm | wb_load | wb_code;
	wire [4:0] wb_idx = wb_imm ? instr_rd : rd_r;
	wire [7:0] wb_data = wb_imm ? instr_k[7:0] : wb_code ? code_byte_r : dmem_rdata;
	wire wb_hi = wb_idx >= PTR_FIRST_IDX;
	wire [1:0] wb_pair = 2'(wb_idx[2:1] - 2'h1);

	// code write reads R0 and R1 on the two ports
	wire [4:0] raddr_a = op_code_wr ? CODE_LO_IDX : instr_rr;

	fdx_regmem #(.WIDTH(8), .DEPTH(REG_COUNT), .AW(REG_AW)) u_regs (
		.core_clk(core_clk),
		.reset(reset),
		.we(wb_en & ~wb_hi),
		.waddr(wb_idx),
		.wdata(wb_data),
		.raddr_a(raddr_a),
		.raddr_b(CODE_HI_IDX),
		.rdata_a(rf_a),
		.rdata_b(rf_b)
	);

	// a new operation is taken only from idle and while software enables it
	assign instr_ready = state_r == S_IDLE && ctrl_en_r;

	// sequencer: one-cycle ops stay idle, memory ops add one or two cycles
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE: begin
				if (accept && op_code_rd) begin
					state_nxt = S_PRD;
				end else if (accept && op_two) begin
					state_nxt = S_ACC;
				end
			end
			S_ACC: state_nxt = S_IDLE;
			S_PRD: state_nxt = S_PWB;
			S_PWB: state_nxt = S_IDLE;
			default: state_nxt = S_IDLE;
		endcase
	end

	// flag changes from instructions override a same-cycle software write
	always_comb begin
		flags_nxt = flags_r;
		if (ahb_wr_r && ahb_addr_r == OFS_FLAGS) begin
			flags_nxt = hwdata[7:0];
		end
		if (accept && instr_op == OP_FLAG_SET) begin
			flags_nxt[instr_k[2:0]] = 1'b1;
		end else if (accept && instr_op == OP_FLAG_CLR) begin
			flags_nxt[instr_k[2:0]] = 1'b0;
		end
	end

	// stack pointer: push or pop wins over a software write
	always_comb begin
		sp_nxt = sp_r;
		if (ahb_wr_r && ahb_addr_r == OFS_SP) begin
			sp_nxt = hwdata[15:0];
		end
		if (accept && (op_push || op_pop)) begin
			sp_nxt = s_next;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_r <= S_IDLE;
			flags_r <= FLAGS_RESET;
			sp_r <= SP_RESET;
		end else begin
			state_r <= state_nxt;
			flags_r <= flags_nxt;
			sp_r <= sp_nxt;
		end
	end

	// pointer flops: moved at accept, loads into pointer bytes land a cycle later
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ptr_r[0] <= PTR_RESET;
			ptr_r[1] <= PTR_RESET;
			ptr_r[2] <= PTR_RESET;
		end else if (wb_en && wb_hi) begin
			if (wb_idx[0]) begin
				ptr_r[wb_pair][15:8] <= wb_data;
			end else begin
				ptr_r[wb_pair][7:0] <= wb_data;
			end
		end else if (ptr_move) begin
			ptr_r[psel] <= p_next;
		end
	end

	// operand capture, refreshed every cycle so it matches the accepted source
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			src_hi_r <= 1'b0;
			src_byte_r <= 8'h00;
		end else begin
			src_hi_r <= rr_hi;
			src_byte_r <= rr_byte;
		end
	end

	// destination index and code byte lane kept across the extra cycles
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rd_r <= 5'h00;
			code_hi_r <= 1'b0;
		end else if (accept) begin
			rd_r <= instr_rd;
			code_hi_r <= psel_val[0];
		end
	end

	// data memory strobes, high exactly in the cycle after accept
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dmem_addr_r <= '0;
			dmem_re_r <= 1'b0;
			dmem_we_r <= 1'b0;
		end else begin
			dmem_re_r <= accept & op_load;
			dmem_we_r <= accept & op_store;
			if (accept && (op_load || op_store)) begin
				dmem_addr_r <= ADDR_W'(mem_addr);
			end
		end
	end

	// code memory: word address from Z, byte lane picked by Z bit 0
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pmem_addr_r <= '0;
			pmem_re_r <= 1'b0;
			pmem_we_r <= 1'b0;
			code_byte_r <= 8'h00;
		end else begin
			pmem_re_r <= accept & op_code_rd;
			pmem_we_r <= accept & op_code_wr;
			if (accept && (op_code_rd || op_code_wr)) begin
				pmem_addr_r <= (ADDR_W-1)'(psel_val[15:1]);
			end
			if (state_r == S_PRD) begin
				code_byte_r <= code_hi_r ? pmem_rdata[15:8] : pmem_rdata[7:0];
			end
		end
	end

	// control pulses go to the sleep, watchdog and debug logic
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sleep_r <= 1'b0;
			wdt_r <= 1'b0;
			break_r <= 1'b0;
		end else begin
			sleep_r <= accept & instr_op == OP_SLEEP;
			wdt_r <= accept & instr_op == OP_WDT_KICK;
			break_r <= accept & instr_op == OP_BREAK & debug_en;
		end
	end

	// AHB-Lite slave: zero wait states, read data prepared at the address phase
	wire ahb_take = hsel & hready & htrans[1];
	wire [31:0] status_word = {27'h0, ~instr_ready, state_r};
	wire [31:0] rd_word = (haddr == OFS_CTRL) ? {31'h0, ctrl_en_r} :
		(haddr == OFS_FLAGS) ? {24'h0, flags_r} :
		(haddr == OFS_STATUS) ? status_word :
		(haddr == OFS_SP) ? {16'h0, sp_r} :
		(haddr == OFS_PTRZ) ? {16'h0, ptr_r[PTR_Z]} : 32'h0;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ahb_wr_r <= 1'b0;
			ahb_addr_r <= '0;
			hrdata_r <= 32'h0;
		end else begin
			ahb_wr_r <= ahb_take & hwrite;
			if (ahb_take) begin
				ahb_addr_r <= haddr;
			end
			if (ahb_take && !hwrite) begin
				hrdata_r <= rd_word;
			end
		end
	end

	// enable bit stops new operations; one in flight still completes
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrl_en_r <= CTRL_RESET[CTRL_EN_BIT];
		end else if (ahb_wr_r && ahb_addr_r == OFS_CTRL) begin
			ctrl_en_r <= hwdata[CTRL_EN_BIT];
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign dmem_addr = dmem_addr_r;
	assign dmem_re = dmem_re_r;
	assign dmem_we = dmem_we_r;
	assign dmem_wdata = src_data;
	assign pmem_addr = pmem_addr_r;
	assign pmem_re = pmem_re_r;
	assign pmem_we = pmem_we_r;
	assign pmem_wdata = {rf_b, rf_a};
	assign sleep_req = sleep_r;
	assign wdt_kick = wdt_r;
	assign break_req = break_r;
	assign flag_register = flags_r;
endmodule

// ---- verilog/fdx_pkg.sv ----
// Purpose: shared constants and types of the flag and data transfer executor
// Assumes: 100 MHz core_clk, AHB-Lite register access, decoded instruction fields
// Notes: register offsets are byte addresses of aligned 32-bit words
package fdx_pkg;
	// register file shape; pointer pairs sit at the top of the file
	localparam int REG_COUNT = 32;
	localparam int REG_AW = 5;
	localparam logic [4:0] PTR_FIRST_IDX = 5'h1A;
	localparam logic [4:0] CODE_LO_IDX = 5'h00;
	localparam logic [4:0] CODE_HI_IDX = 5'h01;

	// pointer selectors
	localparam logic [1:0] PTR_X = 2'h0;
	localparam logic [1:0] PTR_Y = 2'h1;
	localparam logic [1:0] PTR_Z = 2'h2;

	// flag_register bit positions
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_T = 3'h6;
	localparam logic [2:0] FLAG_I = 3'h7;

	// values after reset
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [15:0] SP_RESET = 16'h00FF;
	localparam logic [15:0] PTR_RESET = 16'h0000;
	localparam logic [31:0] CTRL_RESET = 32'h00000001;

	// register map offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FLAGS = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_SP = 8'h0C;
	localparam logic [7:0] OFS_PTRZ = 8'h10;

	// field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int STATUS_BUSY_BIT = 4;

	// operations handed over by the decoder in front of this block
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_FLAG_SET = 4'h1,
		OP_FLAG_CLR = 4'h2,
		OP_LOAD_IMM = 4'h3,
		OP_FETCH_IND = 4'h4,
		OP_SAVE_IND = 4'h5,
		OP_FETCH_DIR = 4'h6,
		OP_SAVE_DIR = 4'h7,
		OP_CODE_FETCH = 4'h8,
		OP_CODE_WRITE = 4'h9,
		OP_PUSH = 4'hA,
		OP_POP = 4'hB,
		OP_SLEEP = 4'hC,
		OP_WDT_KICK = 4'hD,
		OP_BREAK = 4'hE
	} fdx_op_t;

	// pointer addressing modes
	typedef enum logic [2:0] {
		AM_PLAIN = 3'h0,
		AM_POST_INC = 3'h1,
		AM_PRE_DEC = 3'h2,
		AM_DISP = 3'h3,
		AM_POST_DEC = 3'h4,
		AM_PRE_INC = 3'h5
	} fdx_amode_t;

	// execution states, one-hot
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_ACC = 4'b0010,
		S_PRD = 4'b0100,
		S_PWB = 4'b1000
	} fdx_state_t;
endpackage

// ---- verilog/fdx_regmem.sv ----
// Purpose: working register storage with two registered read ports
// Assumes: one write port, write and read in the same cycle return old data
// Notes: contents are not reset, read registers are
`timescale 1ns/10ps
module fdx_regmem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr_a,
	input wire logic [AW-1:0] raddr_b,
	output logic [WIDTH-1:0] rdata_a,
	output logic [WIDTH-1:0] rdata_b
);
	logic [WIDTH-1:0] mem_r [DEPTH];

	// storage array, no reset so it maps onto plain ram cells
	always_ff @(posedge core_clk) begin
		if (we) begin
			mem_r[waddr] <= wdata;
		end
	end

	// both read ports land in flops one cycle after the address
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rdata_a <= '0;
			rdata_b <= '0;
		end else begin
			rdata_a <= mem_r[raddr_a];
			rdata_b <= mem_r[raddr_b];
		end
	end
endmodule
